// ==== logic/lpsc_ctrl.v ====
/*
  low power state controller: halt, sleep, deep sleep, management mode
  and thermal trip sequencing driven by platform pins.
  assumes request pins are asynchronous and are synchronised here; the
  temperature code arrives synchronous to clk from an on-die sensor.
*/
`timescale 1ns/1ps
`include "lpsc_defines.vh"

// Operation
// R01 - sleep request in halt enters sleep
// R02 - sleep gates all clocks, pll runs
// R03 - sleep ignores snoops and interrupts
// R04 - sleep reacts to reset, release, clock loss
// R05 - sleep release returns halt, restarts clocks
// R06 - deep sleep request in sleep enters deep
// R07 - halt request enters halt, acks on bus
// R08 - halt gates core except bus, interrupt units
// R09 - halt keeps snooping and servicing interrupts
// R10 - halt release restarts clocks, resumes execution
// R11 - halt request asynchronous, bus clock unaffected
// R12 - management irq saves state, enters mode
// R13 - management mode acks then runs handler
// R14 - management irq at reset release tristates
// R15 - over-temperature halts execution, drives trip; code checks it only in run, halt and management, not in sleep or deep
// R16 - indicator asserted while in deep sleep
// R17 - async inputs pass two-flop synchroniser
module lpsc_ctrl #(
  parameter TEMP_W = `LPSC_TEMP_W,
  parameter [TEMP_W-1:0] TRIP_DEGC = `LPSC_TRIP_DEGC
) (
  input wire clk,
  input wire rst_b,
  input wire sleep_request_n,
  input wire deep_sleep_request_n,
  input wire clock_halt_request_n,
  input wire sys_mgmt_irq_n,
  input wire bus_clk_present,
  input wire [TEMP_W-1:0] temp_degc,
  input wire snoop_req,
  input wire irq_req,
  input wire mgmt_exit,
  output reg [`LPSC_GATE_W-1:0] clk_enable,
  output reg pll_enable,
  output reg exec_enable,
  output reg snoop_enable,
  output reg irq_enable,
  output reg snoop_taken,
  output reg irq_taken,
  output reg ack_valid,
  output reg [1:0] ack_code,
  output reg state_save,
  output reg sys_mgmt_mode,
  output reg handler_start,
  output reg outputs_tristate,
  output reg thermal_halt_out_n,
  output reg power_state_ind_n
);
  localparam [5:0] ST_RUN = `LPSC_ST_RUN;
  localparam [5:0] ST_HALT = `LPSC_ST_HALT;
  localparam [5:0] ST_SLEEP = `LPSC_ST_SLEEP;
  localparam [5:0] ST_DEEP = `LPSC_ST_DEEP;
  localparam [5:0] ST_MGMT = `LPSC_ST_MGMT;
  localparam [5:0] ST_TRIP = `LPSC_ST_TRIP;

  wire [3:0] pins_s;
  wire slp_s;
  wire dslp_s;
  wire halt_s;
  wire mgmt_s;
  reg [5:0] state_q;
  reg [5:0] state_d;
  reg mgmt_prev_q;
  reg strap_done_q;
  reg trip_d;

  // R17 two-flop sync
  // R11 async halt request caught here, never gates clk itself
  lpsc_sync #(
    .W(4),
    .RST_VAL(4'hf)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({sleep_request_n, deep_sleep_request_n,
      clock_halt_request_n, sys_mgmt_irq_n}),
    .sync_out(pins_s)
  );

  assign slp_s = ~pins_s[3];
  assign dslp_s = ~pins_s[2];
  assign halt_s = ~pins_s[1];
  assign mgmt_s = ~pins_s[0];

  // gating vector for a given state
  function [`LPSC_GATE_W-1:0] gate_of;
    input [5:0] st;
    begin
      case (st)
        ST_RUN: gate_of = `LPSC_GATE_ALL;
        ST_MGMT: gate_of = `LPSC_GATE_ALL;
        ST_HALT: gate_of = `LPSC_GATE_HALT;
        default: gate_of = `LPSC_GATE_NONE;
      endcase
    end
  endfunction

  // next state; trip has top priority in run, halt and management, is not checked in sleep or deep, and is sticky until reset
  always @* begin
    state_d = state_q;
    // R15 over-temperature trip
    trip_d = (temp_degc > TRIP_DEGC);
    case (state_q)
      ST_RUN: begin
        if (trip_d) begin
          state_d = ST_TRIP;
        // R12 management entry
        end else if (mgmt_s && !mgmt_prev_q) begin
          state_d = ST_MGMT;
        // R07 halt entry
        end else if (halt_s) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (trip_d) begin
          state_d = ST_TRIP;
        // R10 release resumes
        end else if (!halt_s) begin
          state_d = ST_RUN;
        // R01 sleep entry
        end else if (slp_s) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // R04 only release, deep request and clock loss matter here
        // R06 deep sleep entry
        if (dslp_s || !bus_clk_present) begin
          state_d = ST_DEEP;
        // R05 release back to halt
        end else if (!slp_s) begin
          state_d = ST_HALT;
        end
      end
      ST_DEEP: begin
        // leave only once clock is back and deep request gone
        if (!dslp_s && bus_clk_present) begin
          state_d = ST_SLEEP;
        end
      end
      ST_MGMT: begin
        if (trip_d) begin
          state_d = ST_TRIP;
        end else if (mgmt_exit) begin
          state_d = ST_RUN;
        end
      end
      ST_TRIP: state_d = ST_TRIP;
      default: state_d = ST_RUN;
    endcase
  end

  // state and edge memory
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      mgmt_prev_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mgmt_prev_q <= mgmt_s;
      strap_done_q <= 1'b1;
    end
  end

  // registered outputs; enables, mode and indicators from next state, taken flags from current state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_enable <= `LPSC_GATE_ALL;
      pll_enable <= 1'b1;
      exec_enable <= 1'b1;
      snoop_enable <= 1'b1;
      irq_enable <= 1'b1;
      snoop_taken <= 1'b0;
      irq_taken <= 1'b0;
      ack_valid <= 1'b0;
      ack_code <= `LPSC_ACK_NONE;
      state_save <= 1'b0;
      sys_mgmt_mode <= 1'b0;
      handler_start <= 1'b0;
      outputs_tristate <= 1'b0;
      thermal_halt_out_n <= 1'b1;
      power_state_ind_n <= 1'b1;
    end else begin
      // R02 R08 clock gating per state; pll stays on
      clk_enable <= gate_of(state_d);
      pll_enable <= 1'b1;
      // R10 R15 execution only in run or management
      exec_enable <= (state_d == ST_RUN) || (state_d == ST_MGMT);
      // R03 R09 snoops and interrupts off in sleep and deeper
      snoop_enable <= (state_d == ST_RUN) || (state_d == ST_HALT) ||
        (state_d == ST_MGMT);
      irq_enable <= (state_d == ST_RUN) || (state_d == ST_HALT) ||
        (state_d == ST_MGMT);
      snoop_taken <= snoop_req && ((state_q == ST_RUN) ||
        (state_q == ST_HALT) || (state_q == ST_MGMT));
      irq_taken <= irq_req && ((state_q == ST_RUN) ||
        (state_q == ST_HALT) || (state_q == ST_MGMT));
      // R07 R13 one-cycle acknowledge on entry
      ack_valid <= 1'b0;
      ack_code <= `LPSC_ACK_NONE;
      if (state_q == ST_RUN && state_d == ST_HALT) begin
        ack_valid <= 1'b1;
        ack_code <= `LPSC_ACK_HALT;
      end
      // R12 save state as mode entered
      state_save <= (state_q == ST_RUN) && (state_d == ST_MGMT);
      if (state_q == ST_MGMT && state_save) begin
        ack_valid <= 1'b1;
        ack_code <= `LPSC_ACK_MGMT;
      end
      sys_mgmt_mode <= (state_d == ST_MGMT);
      // R13 handler starts after acknowledge
      handler_start <= ack_valid && (ack_code == `LPSC_ACK_MGMT);
      // R14 strap sampled at first edge after release
      if (!strap_done_q) begin
        outputs_tristate <= ~sys_mgmt_irq_n;
      end
      // R15 trip pin sticky until reset
      if (state_d == ST_TRIP) begin
        thermal_halt_out_n <= 1'b0;
      end
      // R16 indicator in deep sleep
      power_state_ind_n <= ~(state_d == ST_DEEP);
    end
  end
endmodule

// ==== logic/lpsc_defines.vh ====
/*
  constants for the low power state controller: state codes, bus
  acknowledge codes, trip threshold and clock period.
  assumes a 100 MHz clock and plain verilog-2005 tools.
*/
`ifndef LPSC_DEFINES_VH
`define LPSC_DEFINES_VH

// clock period in ns
`define LPSC_CLK_PERIOD_NS 10
// trip point in whole degrees c
`define LPSC_TRIP_DEGC 125
// temperature code width
`define LPSC_TEMP_W 8

// one-hot state codes
`define LPSC_ST_RUN 6'h01
`define LPSC_ST_HALT 6'h02
`define LPSC_ST_SLEEP 6'h04
`define LPSC_ST_DEEP 6'h08
`define LPSC_ST_MGMT 6'h10
`define LPSC_ST_TRIP 6'h20

// acknowledge transaction codes on the host bus side
`define LPSC_ACK_NONE 2'h0
`define LPSC_ACK_HALT 2'h1
`define LPSC_ACK_MGMT 2'h2

// clock gate vector bits: core, host bus unit, interrupt unit
`define LPSC_GATE_W 3
`define LPSC_GATE_ALL 3'h7
`define LPSC_GATE_HALT 3'h6
`define LPSC_GATE_NONE 3'h0

`endif

// ==== logic/lpsc_sync.v ====
/*
  two-flop synchroniser for a bank of asynchronous level inputs.
  assumes one clock; reset value given by parameter.
*/
`timescale 1ns/1ps
module lpsc_sync #(
  parameter W = 4,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk,
  input wire rst_b,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== tb/lpsc_chipset.sv ====
/* chipset pin model: drives the four request pins, active low.
   assumes the bench changes want just after rising clk edges. */
`timescale 1ns/1ps
module lpsc_chipset (
  input wire clk,
  input wire [3:0] want,
  output reg sleep_request_n,
  output reg deep_sleep_request_n,
  output reg clock_halt_request_n,
  output reg sys_mgmt_irq_n
);
  // idle high until the first edge, so no unknown reaches the pins
  initial {sleep_request_n, deep_sleep_request_n, clock_halt_request_n,
    sys_mgmt_irq_n} = 4'hf;
  // levels, registered on the block's own rising clk edge
  always @(posedge clk) begin
    {sleep_request_n, deep_sleep_request_n, clock_halt_request_n,
      sys_mgmt_irq_n} <= ~want;
  end
endmodule

// ==== tb/lpsc_ctrl_sva.sv ====
/* checker for the state controller outputs.
   assumes one clock and the 3-edge pin latency of the controller. */
`timescale 1ns/1ps
module lpsc_ctrl_chk #(
  parameter TEMP_W = 8,
  parameter [TEMP_W-1:0] TRIP_DEGC = 125
) (
  input wire clk,
  input wire rst_b,
  input wire clock_halt_request_n,
  input wire sleep_request_n,
  input wire [TEMP_W-1:0] temp_degc,
  input wire snoop_req,
  input wire [2:0] clk_enable,
  input wire pll_enable,
  input wire exec_enable,
  input wire snoop_enable,
  input wire irq_enable,
  input wire snoop_taken,
  input wire ack_valid,
  input wire [1:0] ack_code,
  input wire state_save,
  input wire sys_mgmt_mode,
  input wire handler_start,
  input wire thermal_halt_out_n,
  input wire power_state_ind_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // entry steps of management mode and of halt
  sequence s_mgmt;
    state_save && sys_mgmt_mode ##1 ack_valid && ack_code == 2'h2
      ##1 handler_start;
  endsequence
  sequence s_halt;
    exec_enable [*2] ##1 ack_valid && ack_code == 2'h1
      && clk_enable == 3'h6;
  endsequence
  AST_MGMT_SEQ: assert property ($rose(state_save) |-> s_mgmt)
    else $error("management entry steps out of order");
  AST_HALT_LAT: assert property ($fell(clock_halt_request_n)
    && clk_enable == 3'h7 && !sys_mgmt_mode |=> s_halt)
    else $error("halt entry timing wrong");
  AST_HALT_SNOOP: assert property (clk_enable == 3'h6 |->
    snoop_enable && irq_enable && pll_enable)
    else $error("halt lost snoop or interrupt service");
  AST_SLEEP_GATE: assert property (clk_enable == 3'h0 &&
    thermal_halt_out_n |-> !snoop_enable && !irq_enable && pll_enable)
    else $error("sleep gating wrong");
  AST_NO_TAKE: assert property (snoop_req && !snoop_enable |=>
    !snoop_taken) else $error("snoop taken while disabled");
  AST_DEEP_IND: assert property (!power_state_ind_n |->
    clk_enable == 3'h0 && !exec_enable)
    else $error("indicator outside deep sleep");
  AST_RELEASE: assert property (clk_enable == 3'h6 && sleep_request_n
    && $rose(clock_halt_request_n) |-> ##[1:4] clk_enable == 3'h7
    && exec_enable) else $error("halt release did not resume");
  AST_TRIP: assert property (temp_degc > TRIP_DEGC && exec_enable
    |-> ##[1:4] !thermal_halt_out_n && !exec_enable)
    else $error("over-temperature did not trip");
endmodule
bind lpsc_ctrl lpsc_ctrl_chk #(.TEMP_W(TEMP_W), .TRIP_DEGC(TRIP_DEGC)) u_chk (
  .clk(clk), .rst_b(rst_b), .clock_halt_request_n(clock_halt_request_n),
  .sleep_request_n(sleep_request_n), .temp_degc(temp_degc),
  .snoop_req(snoop_req), .clk_enable(clk_enable), .pll_enable(pll_enable),
  .exec_enable(exec_enable), .snoop_enable(snoop_enable),
  .irq_enable(irq_enable), .snoop_taken(snoop_taken),
  .ack_valid(ack_valid), .ack_code(ack_code), .state_save(state_save),
  .sys_mgmt_mode(sys_mgmt_mode), .handler_start(handler_start),
  .thermal_halt_out_n(thermal_halt_out_n),
  .power_state_ind_n(power_state_ind_n));

// ==== tb/tb_low_power_state_control.sv ====
/* bench for the state controller with the chipset pin model.
   assumes a 100 MHz clock; want bits: sleep, deep, halt, mgmt. */
`timescale 1ns/1ps
module tb_low_power_state_control;
  logic clk = 0, rst_b = 0, bus_clk_present = 1, snoop_req = 0;
  logic irq_req = 0, mgmt_exit = 0;
  logic [7:0] temp_degc = 8'h19;
  logic [3:0] want = 4'h0;
  wire sl_n, dp_n, ch_n, mi_n, pll_enable, exec_enable, snoop_enable;
  wire irq_enable, snoop_taken, irq_taken, ack_valid, state_save, tri_o;
  wire sys_mgmt_mode, handler_start, thermal_halt_out_n, power_state_ind_n;
  wire [2:0] clk_enable;
  wire [1:0] ack_code;
  int errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  lpsc_chipset u_cs (.clk(clk), .want(want), .sleep_request_n(sl_n),
    .deep_sleep_request_n(dp_n), .clock_halt_request_n(ch_n),
    .sys_mgmt_irq_n(mi_n));
  lpsc_ctrl dut (.clk(clk), .rst_b(rst_b), .sleep_request_n(sl_n),
    .deep_sleep_request_n(dp_n), .clock_halt_request_n(ch_n),
    .sys_mgmt_irq_n(mi_n), .bus_clk_present(bus_clk_present),
    .temp_degc(temp_degc), .snoop_req(snoop_req), .irq_req(irq_req),
    .mgmt_exit(mgmt_exit), .clk_enable(clk_enable), .pll_enable(pll_enable),
    .exec_enable(exec_enable), .snoop_enable(snoop_enable),
    .irq_enable(irq_enable), .snoop_taken(snoop_taken),
    .irq_taken(irq_taken), .ack_valid(ack_valid), .ack_code(ack_code),
    .state_save(state_save), .sys_mgmt_mode(sys_mgmt_mode),
    .handler_start(handler_start), .outputs_tristate(tri_o),
    .thermal_halt_out_n(thermal_halt_out_n),
    .power_state_ind_n(power_state_ind_n));
  task give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // wait targets, polled after each edge has settled
  function logic hit(input int s);
    case (s)
      0: hit = ack_valid;
      1: hit = clk_enable == 3'h0;
      2: hit = !power_state_ind_n;
      3: hit = power_state_ind_n;
      4: hit = clk_enable == 3'h6;
      5: hit = exec_enable;
      6: hit = state_save;
      default: hit = !thermal_halt_out_n;
    endcase
  endfunction
  task wt(input int s);
    int i;
    // first look only after the launching edge has settled
    #1;
    for (i = 0; i < 20 && hit(s) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 20) begin
      errors++;
      $display("Error wait %0d expected 1 seen 0", s);
      give_verdict;
    end
  endtask
  task go(input logic [3:0] w);
    @(posedge clk) want <= w;
  endtask
  // one-cycle snoop or interrupt request, taken shows one edge later
  task poke(input logic irq);
    @(posedge clk) {snoop_req, irq_req} <= {!irq, irq};
    @(posedge clk) {snoop_req, irq_req} <= 2'h0;
    #1;
  endtask
  task rst(input logic [3:0] w);
    @(posedge clk) {rst_b, want, temp_degc} <= {1'b0, w, 8'h19};
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task t_tri;
    rst(4'h1);
    chk("outputs_tristate", 1, tri_o);
    rst(4'h0);
    chk("outputs_tristate", 0, tri_o);
  endtask
  task t_halt;
    go(4'h2);
    wt(0);
    chk("ack_code", 1, ack_code);
    chk("clk_enable", 6, clk_enable);
    poke(0);
    chk("snoop_taken", 1, snoop_taken);
    poke(1);
    chk("irq_taken", 1, irq_taken);
    go(4'h0);
    wt(5);
    chk("clk_enable", 7, clk_enable);
  endtask
  task t_sleep;
    go(4'h2);
    wt(4);
    go(4'h8 | 4'h2);
    wt(1);
    chk("pll_enable", 1, pll_enable);
    poke(1);
    chk("irq_taken", 0, irq_taken);
    poke(0);
    chk("snoop_taken", 0, snoop_taken);
    go(4'hb);
    repeat (5) @(posedge clk);
    #1;
    chk("sys_mgmt_mode", 0, sys_mgmt_mode);
    // bus clock loss in sleep drops to deep, its return comes back
    @(posedge clk) bus_clk_present <= 1'b0;
    wt(2);
    @(posedge clk) bus_clk_present <= 1'b1;
    wt(3);
    go(4'he);
    wt(2);
    go(4'ha);
    wt(3);
    go(4'h2);
    wt(4);
    chk("exec_enable", 0, exec_enable);
    chk("clk_enable", 6, clk_enable);
    go(4'h0);
    wt(5);
  endtask
  task t_mgmt;
    go(4'h1);
    wt(6);
    chk("sys_mgmt_mode", 1, sys_mgmt_mode);
    @(posedge clk);
    #1;
    chk("ack_code", 2, ack_code);
    @(posedge clk);
    #1;
    chk("handler_start", 1, handler_start);
    // one-cycle exit pulse leaves management mode
    @(posedge clk) mgmt_exit <= 1'b1;
    @(posedge clk) mgmt_exit <= 1'b0;
    #1;
    chk("sys_mgmt_mode", 0, sys_mgmt_mode);
    chk("exec_enable", 1, exec_enable);
  endtask
  task t_trip;
    rst(4'h0);
    @(posedge clk) temp_degc <= 8'h7d;
    repeat (4) @(posedge clk);
    #1;
    chk("thermal_halt_out_n", 1, thermal_halt_out_n);
    @(posedge clk) temp_degc <= 8'h7e;
    wt(7);
    chk("exec_enable", 0, exec_enable);
  endtask
  initial begin
    t_tri;
    t_halt;
    t_sleep;
    t_mgmt;
    t_trip;
    give_verdict;
  end
endmodule
